// ### verilog/dram_pin_mux.sv
`timescale 1ns/1ps
`include "dram_pin_mux_consts.svh"
module dram_pin_mux
  import dram_pin_mux_pkg::*;
#(
  parameter int AW = `ADDR_WIDTH,
  parameter int DW = `DATA_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] cycle_kind,
  input wire logic row_phase,
  input wire logic mem_write,
  input wire logic [AW-1:0] row_addr,
  input wire logic [AW-1:0] col_addr,
  input wire logic [`SEL_WIDTH-1:0] enc_sel_code,
  input wire logic periph_write,
  input wire logic [DW-1:0] periph_wr_data,
  input wire logic parity_low_gen,
  input wire logic parity_high_gen,
  input wire logic [`STROBE_WIDTH-1:0] row_strobe_req_n,
  input wire logic [`STROBE_WIDTH-1:0] col_high_req_n,
  input wire logic [`STROBE_WIDTH-1:0] col_low_req_n,
  input wire logic [1:0] parity_cfg,
  input wire logic powerdown,
  input wire logic refresh_req,
  input wire logic master_reset_in_n,
  input wire logic powerdown_refresh_clk,
  input wire logic pm_sample_in,
  input wire logic [`PM_WIDTH-1:0] pm_inputs,
  input wire logic [AW-1:0] dram_mux_addr_in,
  input wire logic parity_low_in,
  input wire logic parity_high_in,
  input wire logic strobe_mode_strap,
  input wire logic parity_err_in,
  input wire logic copro_irq_in,
  output logic [AW-1:0] dram_mux_addr_out,
  output logic [DW-1:0] periph_bus_oe_n,
  output logic parity_low_out,
  output logic parity_low_oe_n,
  output logic parity_high_out,
  output logic parity_high_oe_n,
  output logic [DW-1:0] periph_rd_data,
  output logic [`STROBE_WIDTH-1:0] row_strobe_n,
  output logic [`STROBE_WIDTH-1:0] col_strobe_high_n,
  output logic [`STROBE_WIDTH-1:0] col_strobe_high_oe_n,
  output logic [`STROBE_WIDTH-1:0] col_strobe_low_n,
  output logic [`STROBE_WIDTH-1:0] col_strobe_low_oe_n,
  output logic strap_pullup_en,
  output logic input_mode,
  output logic parity_err_event,
  output logic irq13_req,
  output logic write_read,
  output logic refresh_out,
  output logic [`PM_WIDTH-1:0] pm_sampled,
  output logic pm_sample_done
);
  if (AW <= DW || AW - DW != `SEL_TOP_COUNT)
  begin : g_bad_width
    $error("address width must exceed data width by the select field");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [`PIN_COUNT-1:0] pin_level;
  logic [`PIN_COUNT-1:0] pin_rise;
  logic [DW+`PM_WIDTH-1:0] bus_level;
  pin_sync_edge #(.WIDTH(`PIN_COUNT)) ctl_sync (
    .clock(clock),
    .rst(rst),
    .pin({powerdown_refresh_clk, master_reset_in_n, pm_sample_in, copro_irq_in,
          parity_err_in, ~strobe_mode_strap}),
    .level(pin_level),
    .rise(pin_rise)
  );
  pin_sync_edge #(.WIDTH(DW + `PM_WIDTH)) bus_sync (
    .clock(clock),
    .rst(rst),
    .pin({dram_mux_addr_in[DW-1:0], pm_inputs}),
    .level(bus_level),
    .rise()
  );

  // ****************************************
  // decode
  // ****************************************
  wire mreset_low = ~pin_level[`PIN_MRESET];
  wire is_mem = cycle_kind == cycle_mem;
  wire is_io = cycle_kind == cycle_io;
  strobe_mode_type mode_reg;
  strobe_mode_type mode_next;
  wire in_mode = mode_reg == mode_input;
  wire parity_pin_on = in_mode && parity_cfg == `CFG_PARITY_ON;
  wire [AW-1:0] mem_addr = row_phase ? row_addr : col_addr;
  wire [AW-1:0] io_addr = {enc_sel_code[`SEL_TOP_COUNT-1:0], periph_wr_data};
  wire [AW-1:0] addr_next = is_mem ? mem_addr : (is_io ? io_addr : '0);
  wire bus_drive = !(is_io && !periph_write);
  wire par_lo_next = is_io ? enc_sel_code[`SEL_TOP_COUNT] : parity_low_gen;
  wire par_hi_next = is_io ? enc_sel_code[`SEL_TOP_COUNT+1] : parity_high_gen;
  wire par_drive = is_io || (is_mem && mem_write);
  wire strap_release = mreset_low || in_mode;
  wire [`STROBE_WIDTH-1:0] hi_oe_n_next = {strap_release, 3'h0};
  wire [`STROBE_WIDTH-1:0] lo_oe_n_next = {parity_pin_on, in_mode, 2'h0};
  wire refresh_next = powerdown ? pin_level[`PIN_REFCLK] : refresh_req;

  // strap follows the pin while master reset is low, frozen at release
  // strap synced inverted, so a flushed synchroniser reads as pulled up
  always_comb
  begin
    mode_next = mode_reg;
    if (mreset_low)
    begin
      mode_next = pin_level[`PIN_STRAP] ? mode_input : mode_output;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] bus_oe_n_reg;
  logic par_lo_reg;
  logic par_hi_reg;
  logic par_oe_n_reg;
  logic [DW-1:0] rd_data_reg;
  logic [`STROBE_WIDTH-1:0] row_stb_reg;
  logic [`STROBE_WIDTH-1:0] col_hi_reg;
  logic [`STROBE_WIDTH-1:0] col_lo_reg;
  logic [`STROBE_WIDTH-1:0] hi_oe_n_reg;
  logic [`STROBE_WIDTH-1:0] lo_oe_n_reg;
  logic pullup_reg;
  logic perr_reg;
  logic irq_reg;
  logic wr_reg;
  logic refresh_reg;
  logic [`PM_WIDTH-1:0] pm_reg;
  logic pm_done_reg;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_reg <= mode_output;
      addr_reg <= '0;
      bus_oe_n_reg <= '1;
      par_lo_reg <= 1'b0;
      par_hi_reg <= 1'b0;
      par_oe_n_reg <= 1'b1;
      row_stb_reg <= `STROBE_IDLE;
      col_hi_reg <= `STROBE_IDLE;
      col_lo_reg <= `STROBE_IDLE;
      hi_oe_n_reg <= 4'h8;
      lo_oe_n_reg <= 4'h0;
      pullup_reg <= 1'b1;
      wr_reg <= 1'b0;
      refresh_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      addr_reg <= addr_next;
      bus_oe_n_reg <= {DW{~bus_drive}};
      par_lo_reg <= par_lo_next;
      par_hi_reg <= par_hi_next;
      par_oe_n_reg <= ~par_drive;
      row_stb_reg <= row_strobe_req_n;
      col_hi_reg <= col_high_req_n;
      col_lo_reg <= col_low_req_n;
      hi_oe_n_reg <= hi_oe_n_next;
      lo_oe_n_reg <= lo_oe_n_next;
      pullup_reg <= mreset_low;
      wr_reg <= is_mem ? mem_write : wr_reg;
      refresh_reg <= refresh_next;
    end
  end

  // ****************************************
  // events and sampled data
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      perr_reg <= 1'b0;
      irq_reg <= 1'b0;
      rd_data_reg <= '0;
      pm_reg <= '0;
      pm_done_reg <= 1'b0;
    end
    else
    begin
      perr_reg <= parity_pin_on && pin_rise[`PIN_PARITY];
      irq_reg <= in_mode && pin_rise[`PIN_COPRO];
      if (is_io && !periph_write)
      begin
        rd_data_reg <= bus_level[DW+`PM_WIDTH-1:`PM_WIDTH];
      end
      if (pin_rise[`PIN_PMSAMPLE])
      begin
        pm_reg <= bus_level[`PM_WIDTH-1:0];
      end
      pm_done_reg <= pin_rise[`PIN_PMSAMPLE];
    end
  end

  assign dram_mux_addr_out = addr_reg;
  assign periph_bus_oe_n = bus_oe_n_reg;
  assign parity_low_out = par_lo_reg;
  assign parity_high_out = par_hi_reg;
  assign parity_low_oe_n = par_oe_n_reg;
  assign parity_high_oe_n = par_oe_n_reg;
  assign periph_rd_data = rd_data_reg;
  assign row_strobe_n = row_stb_reg;
  assign col_strobe_high_n = col_hi_reg;
  assign col_strobe_low_n = col_lo_reg;
  assign col_strobe_high_oe_n = hi_oe_n_reg;
  assign col_strobe_low_oe_n = lo_oe_n_reg;
  assign strap_pullup_en = pullup_reg;
  assign input_mode = in_mode;
  assign parity_err_event = perr_reg;
  assign irq13_req = irq_reg;
  assign write_read = wr_reg;
  assign refresh_out = refresh_reg;
  assign pm_sampled = pm_reg;
  assign pm_sample_done = pm_done_reg;

  // ****************************************
  // checks
  // ****************************************
  chk_row_col_addr: assert property (@(posedge clock) disable iff (rst)
    is_mem |=> dram_mux_addr_out == $past(row_phase ? row_addr : col_addr))
    else $error("memory address not row then column");
  chk_io_select: assert property (@(posedge clock) disable iff (rst)
    is_io |=> {parity_high_out, parity_low_out, dram_mux_addr_out[AW-1:DW]}
      == $past(enc_sel_code) && !parity_low_oe_n)
    else $error("select code not on pins");
  chk_periph_read: assert property (@(posedge clock) disable iff (rst)
    (is_io && !periph_write) |=> periph_bus_oe_n == '1)
    else $error("data bus driven during read");
  chk_strap_pullup: assert property (@(posedge clock) disable iff (rst)
    mreset_low |=> strap_pullup_en && col_strobe_high_oe_n[3])
    else $error("strap pin not released in reset");
  chk_mode_latch: assert property (@(posedge clock) disable iff (rst)
    (mreset_low && pin_level[`PIN_STRAP]) ##1 !mreset_low [*3] |-> input_mode)
    else $error("input mode not kept after release");
  chk_out_mode_drive: assert property (@(posedge clock) disable iff (rst)
    (!input_mode && !mreset_low) [*2] |-> col_strobe_low_oe_n == 4'h0
      && col_strobe_high_oe_n == 4'h0)
    else $error("strobe released in output mode");
  chk_parity_event: assert property (@(posedge clock) disable iff (rst)
    parity_err_event |-> $past(parity_pin_on) && $past(pin_level[`PIN_PARITY])
      && !$past(pin_level[`PIN_PARITY], 2))
    else $error("parity event without rising edge");
  chk_copro_irq: assert property (@(posedge clock) disable iff (rst)
    (in_mode && pin_rise[`PIN_COPRO]) |=> irq13_req ##1 !irq13_req)
    else $error("coprocessor edge did not raise one request");
  chk_write_read: assert property (@(posedge clock) disable iff (rst)
    is_mem |=> write_read == $past(mem_write))
    else $error("write read level wrong");
  chk_pd_refresh: assert property (@(posedge clock) disable iff (rst)
    powerdown |=> refresh_out == $past(pin_level[`PIN_REFCLK]))
    else $error("refresh clock not routed in power down");
endmodule : dram_pin_mux

// ### verilog/dram_pin_mux_consts.svh
`ifndef DRAM_PIN_MUX_CONSTS_SVH
`define DRAM_PIN_MUX_CONSTS_SVH
`define ADDR_WIDTH 11
`define DATA_WIDTH 8
`define SEL_WIDTH 5
`define STROBE_WIDTH 4
`define PM_WIDTH 8
`define SEL_TOP_COUNT 3
`define CFG_PORT_ADDR 16'h3872
`define CFG_PARITY_BIT_HI 13
`define CFG_PARITY_BIT_LO 12
`define CFG_PARITY_ON 2'h3
`define IRQ_COPRO_LINE 4'hd
`define STROBE_IDLE 4'hf
`define SYNC_STAGES 2
`define PIN_STRAP 0
`define PIN_PARITY 1
`define PIN_COPRO 2
`define PIN_PMSAMPLE 3
`define PIN_MRESET 4
`define PIN_REFCLK 5
`define PIN_COUNT 6
`endif

// ### verilog/dram_pin_mux_pkg.sv
package dram_pin_mux_pkg;
  typedef enum logic [1:0]
  {
    cycle_idle = 2'b00,
    cycle_mem = 2'b01,
    cycle_io = 2'b11
  } cycle_kind_type;
  typedef enum logic
  {
    mode_output = 1'b0,
    mode_input = 1'b1
  } strobe_mode_type;
endpackage : dram_pin_mux_pkg

// ### verilog/pin_sync_edge.sv
`timescale 1ns/1ps
module pin_sync_edge #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] prev_reg;
  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_sync_edge width must be at least one");
  end
  // two-stage synchroniser then history
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      stage1_reg <= pin;
      stage2_reg <= stage1_reg;
      prev_reg <= stage2_reg;
    end
  end
  assign level = stage2_reg;
  assign rise = stage2_reg & ~prev_reg;
endmodule : pin_sync_edge

// ### testbench/dram_far_side.sv
`timescale 1ns/1ps
// ********************************
// board side: strap, peripheral, refresh source
// ********************************
module dram_far_side (
  input wire logic strap_low,
  input wire logic hi_oe_n,
  input wire logic hi_out,
  input wire logic [7:0] kb_data,
  input wire logic [10:0] addr_out,
  input wire logic [7:0] bus_oe_n,
  output logic strap_pin,
  output logic [10:0] addr_pin,
  output logic ref_clk
);
  // board pull-down in reset beats the weak pull-up
  assign strap_pin = !hi_oe_n ? hi_out : !strap_low;
  // peripheral answers on released data lines
  assign addr_pin = {addr_out[10:8],
    (addr_out[7:0] & ~bus_oe_n) | (kb_data & bus_oe_n)};
  initial ref_clk = 1'b0;
  // free-running 64 kHz refresh source
  always #7800 ref_clk = ~ref_clk;
endmodule : dram_far_side

// ### testbench/test_dram_pin_mux.sv
`timescale 1ns/1ps
module test_dram_pin_mux;
  import dram_pin_mux_pkg::*;
  logic clock, rst, row_phase, mem_write, periph_write, parity_low_gen, parity_high_gen;
  logic powerdown, refresh_req, master_reset_in_n, pm_sample_in, parity_err_in;
  logic copro_irq_in, strap_low, parity_low_out, parity_low_oe_n, parity_high_out;
  logic parity_high_oe_n, strap_pullup_en, input_mode, parity_err_event, irq13_req;
  logic write_read, refresh_out, pm_sample_done, strobe_mode_strap, powerdown_refresh_clk;
  logic [1:0] cycle_kind, parity_cfg;
  logic [10:0] row_addr, col_addr, dram_mux_addr_in, dram_mux_addr_out;
  logic [4:0] enc_sel_code, hist;
  logic [7:0] periph_wr_data, pm_inputs, kb_data, periph_bus_oe_n, periph_rd_data, pm_sampled;
  logic [3:0] row_strobe_req_n, col_high_req_n, col_low_req_n, row_strobe_n;
  logic [3:0] col_strobe_high_n, col_strobe_high_oe_n, col_strobe_low_n, col_strobe_low_oe_n;
  wire parity_low_in = parity_low_out;
  wire parity_high_in = parity_high_out;
  int error_cnt = 0;
  int check_count = 0;
  dram_pin_mux u_dram_pin_mux (.*);
  dram_far_side u_dram_far_side (.strap_low(strap_low), .hi_oe_n(col_strobe_high_oe_n[3]),
    .hi_out(col_strobe_high_n[3]), .kb_data(kb_data), .addr_out(dram_mux_addr_out),
    .bus_oe_n(periph_bus_oe_n), .strap_pin(strobe_mode_strap),
    .addr_pin(dram_mux_addr_in), .ref_clk(powerdown_refresh_clk));
  // ********************************
  // helpers
  // ********************************
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // ********************************
  // scenarios
  // ********************************
  task t_mode(input logic lo);
    master_reset_in_n = 1'b0;
    strap_low = lo;
    step(6);
    chk("pullup", strap_pullup_en, 1);
    chk("hi_oe3", col_strobe_high_oe_n[3], 1);
    master_reset_in_n = 1'b1;
    step(1);
    strap_low = 1'b0;
    parity_cfg = 2'h0;
    col_high_req_n = 4'h5;
    col_low_req_n = 4'ha;
    step(5);
    chk("mode", input_mode, lo);
    chk("hi_oe", col_strobe_high_oe_n, lo ? 4'h8 : 4'h0);
    chk("lo_oe", col_strobe_low_oe_n, lo ? 4'h4 : 4'h0);
    chk("hi_n", col_strobe_high_n[2:0], 3'h5);
    chk("lo_n", col_strobe_low_n, 4'ha);
    parity_cfg = 2'h3;
    step(2);
    chk("lo_oe", col_strobe_low_oe_n, lo ? 4'hc : 4'h0);
    $display("mode test done");
  endtask : t_mode
  task t_edge(input logic irq, input logic exp);
    if (irq)
      copro_irq_in = 1'b1;
    else
      parity_err_in = 1'b1;
    step(3);
    chk("event", irq ? irq13_req : parity_err_event, exp);
    step(1);
    chk("event end", irq ? irq13_req : parity_err_event, 0);
    parity_err_in = 1'b0;
    copro_irq_in = 1'b0;
    step(3);
    $display("edge test done");
  endtask : t_edge
  task t_cycles;
    cycle_kind = cycle_mem;
    {row_phase, mem_write, parity_high_gen, parity_low_gen} = 4'hd;
    {row_addr, col_addr, row_strobe_req_n} = {11'h5a3, 11'h2bc, 4'h9};
    step(1);
    chk("row", dram_mux_addr_out, 11'h5a3);
    chk("row_strobe", row_strobe_n, 4'h9);
    row_phase = 1'b0;
    step(1);
    chk("col", dram_mux_addr_out, 11'h2bc);
    chk("wr", write_read, 1);
    chk("par", {parity_low_oe_n, parity_high_out, parity_low_out}, 3'h1);
    mem_write = 1'b0;
    step(1);
    chk("rd", write_read, 0);
    {cycle_kind, periph_write, periph_wr_data} = {cycle_io, 1'b1, 8'hc3};
    for (int i = 0; i < 32; i++)
    begin
      enc_sel_code = i[4:0];
      step(1);
      chk("sel", {parity_high_out, parity_low_out, dram_mux_addr_out[10:8]}, i);
      chk("pbus", {periph_bus_oe_n, dram_mux_addr_out[7:0]}, 16'h00c3);
    end
    {periph_write, kb_data} = {1'b0, 8'h69};
    step(1);
    chk("pbus_oe", periph_bus_oe_n, 8'hff);
    step(4);
    chk("pbus_rd", periph_rd_data, 8'h69);
    cycle_kind = cycle_idle;
    $display("cycle test done");
  endtask : t_cycles
  task t_power;
    refresh_req = 1'b1;
    step(1);
    chk("ref", refresh_out, 1);
    powerdown = 1'b1;
    hist = 5'h0;
    for (int i = 0; i < 400; i++)
    begin
      step(1);
      hist = {hist[3:0], powerdown_refresh_clk};
      if (i >= 4 && (hist == 5'h1f || hist == 5'h0))
        chk("refclk", refresh_out, hist[0]);
    end
    {powerdown, refresh_req} = 2'h0;
    step(1);
    chk("ref_lo", refresh_out, 0);
    pm_inputs = 8'hd2;
    step(2);
    pm_sample_in = 1'b1;
    step(3);
    chk("pm", {pm_sample_done, pm_sampled}, 9'h1d2);
    step(1);
    chk("pm_done", pm_sample_done, 0);
    $display("power test done");
  endtask : t_power
  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    {rst, master_reset_in_n, strap_low, row_phase, mem_write, periph_write} = 6'h20;
    {parity_low_gen, parity_high_gen, powerdown, refresh_req, pm_sample_in} = 5'h0;
    {parity_err_in, copro_irq_in, cycle_kind, parity_cfg, enc_sel_code} = 11'h0;
    {row_addr, col_addr, periph_wr_data, pm_inputs, kb_data} = 46'h0;
    {row_strobe_req_n, col_high_req_n, col_low_req_n} = 12'hfff;
    step(4);
    rst = 1'b0;
    t_mode(1'b1);
    t_edge(1'b0, 1'b1);
    t_edge(1'b1, 1'b1);
    parity_cfg = 2'h1;
    t_edge(1'b0, 1'b0);
    t_mode(1'b0);
    t_edge(1'b1, 1'b0);
    t_cycles;
    t_power;
    close_out;
  end
  initial
  begin
    #2000000;
    error_cnt++;
    close_out;
  end
endmodule : test_dram_pin_mux
